// ### rtl/sscf_pkg.sv
// Shared constants, types and helpers of the serial command front end
package sscf_pkg;

    // ------------------------------------------------------------
    // Command bytes and configuration values
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_REG_WR = 8'h20;
    localparam logic [7:0] CMD_REG_RD = 8'h21;
    localparam logic [7:0] CMD_ORDER = 8'h18;
    localparam logic [7:0] ORDER_MSB_FIRST = 8'h81;
    localparam logic [7:0] ORDER_LSB_FIRST = 8'h42;
    localparam logic [7:0] READ_FILLER = 8'h00;

    // ------------------------------------------------------------
    // Internal register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_PORT_PIN_CONFIG = 8'h00;
    localparam logic [7:0] REG_PORT_PIN_STATE = 8'h01;
    localparam logic [7:0] REG_BUS_CLOCK_DIVIDER = 8'h02;
    localparam logic [7:0] REG_BUS_TIMEOUT_CFG = 8'h03;
    localparam logic [7:0] REG_BUS_XFER_STATUS = 8'h04;
    localparam logic [7:0] REG_OWN_SLAVE_ADDRESS = 8'h05;
    localparam logic [7:0] REG_RX_BYTE_COUNT = 8'h06;
    localparam logic [7:0] REG_PORT_PIN_CONFIG_TWO = 8'h07;
    localparam logic [7:0] REG_EDGE_IRQ_CONFIG = 8'h08;
    localparam logic [7:0] REG_BUS_EXTRA_TIMEOUTS = 8'h09;
    localparam logic [7:0] REG_COUNT = 8'h0A;

    typedef logic [9:0][7:0] sscf_regs_t;

    // Index 9 first; unknown reset values default to zero
    localparam sscf_regs_t REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                        8'h00, 8'h00, 8'hA0, 8'h00, 8'h00};

    // ------------------------------------------------------------
    // Decoder and host states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DST_CMD = 2'h0,
        DST_ADDR = 2'h1,
        DST_ARG = 2'h3,
        DST_OUT = 2'h2
    } sscf_dst_t;

    typedef enum logic [2:0] {
        HST_IDLE = 3'h0,
        HST_SEL = 3'h1,
        HST_LOW = 3'h3,
        HST_HIGH = 3'h2,
        HST_END = 3'h6,
        HST_GAP = 3'h4
    } sscf_hst_t;

    // ------------------------------------------------------------
    // Host control registers, byte addresses on the Avalon port
    // ------------------------------------------------------------
    localparam logic [3:0] CSR_CMD = 4'h0;
    localparam logic [3:0] CSR_ADDR = 4'h4;
    localparam logic [3:0] CSR_DATA = 4'h8;
    localparam logic [3:0] CSR_STAT = 4'hC;
    localparam logic [1:0] OP_REG_WR = 2'h0;
    localparam logic [1:0] OP_REG_RD = 2'h1;
    localparam logic [1:0] OP_ORDER = 2'h2;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_LSB_BIT = 9;

    // ------------------------------------------------------------
    // Link timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int SCLK_HALF_NS = 200;
    localparam int SCLK_HALF_CYC_INT = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SCLK_HALF_CYC = SCLK_HALF_CYC_INT[7:0];

    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction

endpackage

// ### rtl/sscf_link_if.sv
// Four-wire serial link between the command master and the device
`timescale 1ns/1ps
`default_nettype none
interface sscf_link_if;
    logic sclk;
    logic slave_select_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // Undriven line reads high, as with a pull-up
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev (
        input sclk,
        input slave_select_n,
        input mosi,
        output miso,
        output miso_oe
    );

    modport host (
        output sclk,
        output slave_select_n,
        output mosi,
        input miso_line
    );
endinterface
`default_nettype wire

// ### rtl/sscf_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sscf_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic [1:0] sync_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_reg <= {RST_VAL, RST_VAL};
        end else begin
            sync_reg <= {sync_reg[0], d};
        end
    end

    assign q = sync_reg[1];
endmodule
`default_nettype wire

// ### rtl/sscf_dev.sv
// Device end: serial slave, command decoder and internal register file
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Link active only while select low
// - Master holds serial clock high when idle
// - Sole slave may tie select low
// - Register commands anytime, never start bus traffic
// - Addresses 0x00 to 0x09 map ten registers
// - Write: 0x20, address, value; one register
// - Read: 0x21, address, filler, then value out
// - Filler byte content is ignored
// - MSB-first sends bit 7 first, else bit 0
// - Order command 0x18: 0x81 MSB, 0x42 LSB
// - Other order values leave orientation unchanged
// - No slave response while command arrives, bus idle
// - Stall own bus transfer until command processed
// - Ack own address, refuse data bytes
module sscf_dev (
    input wire logic clk,
    input wire logic rst_n,
    sscf_link_if.dev link,
    input wire logic engine_busy,
    input wire logic [7:0] bus_xfer_status,
    output sscf_pkg::sscf_regs_t cfg_regs,
    output logic slave_resp_en,
    output logic engine_stall
);

    // ------------------------------------------------------------
    // Link domain state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [6:0] shift;
        logic mid_byte;
    } sscf_rx_t;

    typedef struct packed {
        logic [7:0] byte_q;
        logic toggle;
    } sscf_rxh_t;

    typedef struct packed {
        logic [6:0] shift;
        logic miso;
        logic oe;
    } sscf_tx_t;

    // ------------------------------------------------------------
    // System domain state
    // ------------------------------------------------------------
    typedef struct packed {
        sscf_pkg::sscf_dst_t st;
        logic [7:0] cmd;
        logic [7:0] addr;
        logic toggle_seen;
        logic lsb_first;
        logic [7:0] tx_word;
        sscf_pkg::sscf_regs_t regs;
        logic resp_en;
        logic stall;
    } sscf_dev_t;

    sscf_rx_t rx_reg;
    sscf_rx_t rx_next;
    sscf_rxh_t rxh_reg;
    sscf_rxh_t rxh_next;
    sscf_tx_t tx_reg;
    sscf_tx_t tx_next;
    sscf_dev_t dev_reg;
    sscf_dev_t dev_next;
    logic sel_rst_n;
    logic sel_high_s;
    logic toggle_s;
    logic mid_byte_s;

    function automatic logic [7:0] reg_value(input sscf_pkg::sscf_regs_t regs, input logic [7:0] status,
                                             input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        if (addr == sscf_pkg::REG_BUS_XFER_STATUS) begin
            v = status;
        end else if (addr < sscf_pkg::REG_COUNT) begin
            v = regs[addr[3:0]];
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // Receive shifter on rising clock edges
    // ------------------------------------------------------------
    // Select high holds the shifter in reset, so stray clocks do nothing
    assign sel_rst_n = rst_n & ~link.slave_select_n;

    always_comb begin
        rx_next = rx_reg;
        rx_next.bit_cnt = rx_reg.bit_cnt + 3'h1;
        rx_next.shift = {rx_reg.shift[5:0], link.mosi};
        rx_next.mid_byte = (rx_reg.bit_cnt != 3'h7);
    end

    always_ff @(posedge link.sclk or negedge sel_rst_n) begin
        if (!sel_rst_n) begin
            rx_reg <= '0;
        end else begin
            rx_reg <= rx_next;
        end
    end

    // Byte hand-off; not reset by select, or a release would fake an event
    always_comb begin
        rxh_next = rxh_reg;
        if (rx_reg.bit_cnt == 3'h7) begin
            rxh_next.byte_q = {rx_reg.shift, link.mosi};
            rxh_next.toggle = ~rxh_reg.toggle;
        end
    end

    always_ff @(posedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            rxh_reg <= '0;
        end else begin
            rxh_reg <= rxh_next;
        end
    end

    // ------------------------------------------------------------
    // Transmit shifter on falling clock edges
    // ------------------------------------------------------------
    // Word is pre-ordered in the system domain and stable for a whole byte
    always_comb begin
        tx_next = tx_reg;
        tx_next.oe = 1'b1;
        if (rx_reg.bit_cnt == 3'h0) begin
            tx_next.miso = dev_reg.tx_word[7];
            tx_next.shift = dev_reg.tx_word[6:0];
        end else begin
            tx_next.miso = tx_reg.shift[6];
            tx_next.shift = {tx_reg.shift[5:0], 1'b0};
        end
    end

    always_ff @(negedge link.sclk or negedge sel_rst_n) begin
        if (!sel_rst_n) begin
            tx_reg <= '0;
        end else begin
            tx_reg <= tx_next;
        end
    end

    assign link.miso = tx_reg.miso;
    assign link.miso_oe = tx_reg.oe;

    // ------------------------------------------------------------
    // Crossings into the system domain
    // ------------------------------------------------------------
    sscf_sync #(.RST_VAL(1'b1)) u_sync_sel (
        .clk(clk),
        .rst_n(rst_n),
        .d(link.slave_select_n),
        .q(sel_high_s)
    );

    sscf_sync #(.RST_VAL(1'b0)) u_sync_toggle (
        .clk(clk),
        .rst_n(rst_n),
        .d(rxh_reg.toggle),
        .q(toggle_s)
    );

    sscf_sync #(.RST_VAL(1'b0)) u_sync_mid (
        .clk(clk),
        .rst_n(rst_n),
        .d(rx_reg.mid_byte),
        .q(mid_byte_s)
    );

    // ------------------------------------------------------------
    // Command decoder and register file
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] rx_val;
        logic [7:0] rd_val;
        logic cmd_busy;
        rx_val = 8'h00;
        rd_val = 8'h00;
        cmd_busy = 1'b0;
        dev_next = dev_reg;
        dev_next.toggle_seen = toggle_s;
        // Bytes are assembled MSB-first on the link, reordered here
        rx_val = dev_reg.lsb_first ? sscf_pkg::rev8(rxh_reg.byte_q) : rxh_reg.byte_q;
        cmd_busy = (dev_reg.st != sscf_pkg::DST_CMD) || mid_byte_s;
        if (sel_high_s) begin
            dev_next.st = sscf_pkg::DST_CMD;
        end else if (toggle_s != dev_reg.toggle_seen) begin
            case (dev_reg.st)
                sscf_pkg::DST_CMD: begin
                    dev_next.cmd = rx_val;
                    if (rx_val == sscf_pkg::CMD_REG_WR || rx_val == sscf_pkg::CMD_REG_RD) begin
                        dev_next.st = sscf_pkg::DST_ADDR;
                    end else if (rx_val == sscf_pkg::CMD_ORDER) begin
                        dev_next.st = sscf_pkg::DST_ARG;
                    end
                end
                sscf_pkg::DST_ADDR: begin
                    dev_next.addr = rx_val;
                    dev_next.st = sscf_pkg::DST_ARG;
                    if (dev_reg.cmd == sscf_pkg::CMD_REG_RD) begin
                        rd_val = reg_value(dev_reg.regs, bus_xfer_status, rx_val);
                        dev_next.tx_word = dev_reg.lsb_first ? sscf_pkg::rev8(rd_val) : rd_val;
                    end
                end
                sscf_pkg::DST_ARG: begin
                    dev_next.st = sscf_pkg::DST_CMD;
                    if (dev_reg.cmd == sscf_pkg::CMD_REG_WR) begin
                        // Status is read-only; unmapped addresses are dropped
                        if (dev_reg.addr < sscf_pkg::REG_COUNT &&
                            dev_reg.addr != sscf_pkg::REG_BUS_XFER_STATUS) begin
                            dev_next.regs[dev_reg.addr[3:0]] = rx_val;
                        end
                    end else if (dev_reg.cmd == sscf_pkg::CMD_ORDER) begin
                        if (rx_val == sscf_pkg::ORDER_MSB_FIRST) begin
                            dev_next.lsb_first = 1'b0;
                        end else if (rx_val == sscf_pkg::ORDER_LSB_FIRST) begin
                            dev_next.lsb_first = 1'b1;
                        end
                        // Any other value falls through unchanged
                    end else begin
                        // Filler byte consumed without looking at it
                        dev_next.st = sscf_pkg::DST_OUT;
                    end
                end
                sscf_pkg::DST_OUT: begin
                    dev_next.st = sscf_pkg::DST_CMD;
                end
                default: begin
                    dev_next.st = sscf_pkg::DST_CMD;
                end
            endcase
        end
        // Engine sees these; it answers its own address, refuses data bytes
        dev_next.resp_en = (dev_reg.regs[sscf_pkg::REG_OWN_SLAVE_ADDRESS[3:0]] != 8'h00) && !cmd_busy;
        dev_next.stall = cmd_busy && engine_busy;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_reg <= '{st: sscf_pkg::DST_CMD, cmd: 8'h00, addr: 8'h00, toggle_seen: 1'b0, lsb_first: 1'b0,
                         tx_word: 8'h00, regs: sscf_pkg::REG_RESET, resp_en: 1'b0, stall: 1'b0};
        end else begin
            dev_reg <= dev_next;
        end
    end

    assign cfg_regs = dev_reg.regs;
    assign slave_resp_en = dev_reg.resp_en;
    assign engine_stall = dev_reg.stall;

endmodule
`default_nettype wire

// ### rtl/sscf_host.sv
// Host end: link master driven from Avalon-MM control registers
`timescale 1ns/1ps
`default_nettype none
module sscf_host (
    input wire logic clk,
    input wire logic rst_n,
    sscf_link_if.host link,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    typedef struct packed {
        sscf_pkg::sscf_hst_t st;
        logic [7:0] cnt;
        logic [2:0] bit_idx;
        logic [1:0] byte_idx;
        logic [1:0] last_byte;
        logic [1:0] op;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] shift;
        logic [7:0] rx;
        logic [7:0] rdata;
        logic lsb_first;
        logic sclk;
        logic sel_n;
        logic mosi;
        logic wait_req;
        logic [31:0] readdata;
    } sscf_host_t;

    sscf_host_t h_reg;
    sscf_host_t h_next;
    logic miso_s;

    function automatic logic [7:0] frame_byte(input logic [1:0] op, input logic [7:0] addr,
                                              input logic [7:0] wdata, input logic [1:0] idx);
        logic [7:0] b;
        b = sscf_pkg::READ_FILLER;
        case (idx)
            2'h0: b = (op == sscf_pkg::OP_REG_WR) ? sscf_pkg::CMD_REG_WR :
                      (op == sscf_pkg::OP_REG_RD) ? sscf_pkg::CMD_REG_RD : sscf_pkg::CMD_ORDER;
            2'h1: b = (op == sscf_pkg::OP_ORDER) ? wdata : addr;
            2'h2: b = (op == sscf_pkg::OP_REG_WR) ? wdata : sscf_pkg::READ_FILLER;
            default: b = sscf_pkg::READ_FILLER;
        endcase
        return b;
    endfunction

    sscf_sync #(.RST_VAL(1'b1)) u_sync_miso (
        .clk(clk),
        .rst_n(rst_n),
        .d(link.miso_line),
        .q(miso_s)
    );

    // ------------------------------------------------------------
    // Frame sequencer and register port
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] nb;
        nb = 8'h00;
        h_next = h_reg;
        if (h_reg.cnt != 8'h00) begin
            h_next.cnt = h_reg.cnt - 8'h01;
        end
        case (h_reg.st)
            sscf_pkg::HST_IDLE: begin
                h_next.sclk = 1'b1;
                h_next.sel_n = 1'b1;
            end
            sscf_pkg::HST_SEL, sscf_pkg::HST_HIGH: begin
                if (h_reg.cnt == 8'h01) begin
                    nb = h_reg.shift;
                    if (h_reg.st == sscf_pkg::HST_HIGH && h_reg.bit_idx == 3'h7) begin
                        nb = frame_byte(h_reg.op, h_reg.addr, h_reg.wdata, h_reg.byte_idx + 2'h1);
                        nb = h_reg.lsb_first ? sscf_pkg::rev8(nb) : nb;
                        h_next.byte_idx = h_reg.byte_idx + 2'h1;
                    end
                    if (h_reg.st == sscf_pkg::HST_HIGH && h_reg.bit_idx == 3'h7 &&
                        h_reg.byte_idx == h_reg.last_byte) begin
                        h_next.rdata = h_reg.lsb_first ? sscf_pkg::rev8(h_reg.rx) : h_reg.rx;
                        h_next.st = sscf_pkg::HST_END;
                    end else begin
                        h_next.st = sscf_pkg::HST_LOW;
                        h_next.sclk = 1'b0;
                        h_next.mosi = nb[7];
                        h_next.shift = {nb[6:0], 1'b0};
                        h_next.bit_idx = (h_reg.st == sscf_pkg::HST_SEL) ? 3'h0 : h_reg.bit_idx + 3'h1;
                    end
                    h_next.cnt = sscf_pkg::SCLK_HALF_CYC;
                end
            end
            sscf_pkg::HST_LOW: begin
                if (h_reg.cnt == 8'h01) begin
                    h_next.st = sscf_pkg::HST_HIGH;
                    h_next.sclk = 1'b1;
                    h_next.rx = {h_reg.rx[6:0], miso_s};
                    h_next.cnt = sscf_pkg::SCLK_HALF_CYC;
                end
            end
            sscf_pkg::HST_END: begin
                if (h_reg.cnt == 8'h01) begin
                    h_next.st = sscf_pkg::HST_GAP;
                    h_next.sel_n = 1'b1;
                    h_next.cnt = sscf_pkg::SCLK_HALF_CYC;
                    if (h_reg.op == sscf_pkg::OP_ORDER) begin
                        if (h_reg.wdata == sscf_pkg::ORDER_MSB_FIRST) begin
                            h_next.lsb_first = 1'b0;
                        end else if (h_reg.wdata == sscf_pkg::ORDER_LSB_FIRST) begin
                            h_next.lsb_first = 1'b1;
                        end
                    end
                end
            end
            sscf_pkg::HST_GAP: begin
                if (h_reg.cnt == 8'h01) begin
                    h_next.st = sscf_pkg::HST_IDLE;
                end
            end
            default: begin
                h_next.st = sscf_pkg::HST_IDLE;
            end
        endcase

        // Answer one cycle after the request is seen
        h_next.wait_req = 1'b1;
        if ((avs_read || avs_write) && h_reg.wait_req) begin
            h_next.wait_req = 1'b0;
        end
        if (avs_read && h_reg.wait_req) begin
            case (avs_address)
                sscf_pkg::CSR_CMD: h_next.readdata = {30'h0, h_reg.op};
                sscf_pkg::CSR_ADDR: h_next.readdata = {24'h0, h_reg.addr};
                sscf_pkg::CSR_DATA: h_next.readdata = {24'h0, h_reg.wdata};
                sscf_pkg::CSR_STAT: h_next.readdata = {22'h0, h_reg.lsb_first,
                                                       h_reg.st != sscf_pkg::HST_IDLE, h_reg.rdata};
                default: h_next.readdata = 32'h0;
            endcase
        end
        // Writes land only while idle, so a frame never sees its fields change
        if (avs_write && !h_reg.wait_req && h_reg.st == sscf_pkg::HST_IDLE) begin
            case (avs_address)
                sscf_pkg::CSR_ADDR: h_next.addr = avs_writedata[7:0];
                sscf_pkg::CSR_DATA: h_next.wdata = avs_writedata[7:0];
                sscf_pkg::CSR_CMD: begin
                    if (avs_writedata[1:0] != 2'h3) begin
                        h_next.op = avs_writedata[1:0];
                        h_next.last_byte = (avs_writedata[1:0] == sscf_pkg::OP_REG_WR) ? 2'h2 :
                                           (avs_writedata[1:0] == sscf_pkg::OP_REG_RD) ? 2'h3 : 2'h1;
                        nb = frame_byte(avs_writedata[1:0], h_reg.addr, h_reg.wdata, 2'h0);
                        h_next.shift = h_reg.lsb_first ? sscf_pkg::rev8(nb) : nb;
                        h_next.byte_idx = 2'h0;
                        h_next.sel_n = 1'b0;
                        h_next.st = sscf_pkg::HST_SEL;
                        h_next.cnt = sscf_pkg::SCLK_HALF_CYC;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            h_reg <= '{st: sscf_pkg::HST_IDLE, cnt: 8'h00, bit_idx: 3'h0, byte_idx: 2'h0, last_byte: 2'h0,
                       op: 2'h0, addr: 8'h00, wdata: 8'h00, shift: 8'h00, rx: 8'h00, rdata: 8'h00,
                       lsb_first: 1'b0, sclk: 1'b1, sel_n: 1'b1, mosi: 1'b1, wait_req: 1'b1,
                       readdata: 32'h0};
        end else begin
            h_reg <= h_next;
        end
    end

    assign link.sclk = h_reg.sclk;
    assign link.slave_select_n = h_reg.sel_n;
    assign link.mosi = h_reg.mosi;
    assign avs_readdata = h_reg.readdata;
    assign avs_waitrequest = h_reg.wait_req;

endmodule
`default_nettype wire

// ### testbench/sscf_link_checker.sv
// Link timing and engine coordination assertions
`timescale 1ns/1ps
`default_nettype none
module sscf_link_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic slave_select_n,
    input wire logic miso_oe,
    input wire logic engine_busy,
    input wire logic engine_stall,
    input wire logic slave_resp_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_clock_idle: assert property (slave_select_n |-> sclk) else $error("idle clock");
    chk_select_lead: assert property ($fell(slave_select_n) |-> sclk [*2]) else $error("early edge");
    chk_clock_high: assert property ($rose(sclk) |-> sclk [*5]) else $error("short high");
    chk_clock_low: assert property ($fell(sclk) |-> (!sclk) [*5]) else $error("short low");
    chk_miso_free: assert property ($rose(slave_select_n) |-> ##[0:4] !miso_oe) else $error("miso held");
    chk_stall_cause: assert property (engine_stall |-> $past(engine_busy)) else $error("stray stall");
    chk_stall_ends: assert property (slave_select_n [*8] |-> !engine_stall) else $error("stall stuck");
    chk_resp_quiet: assert property (engine_stall |-> !slave_resp_en) else $error("slave answers");
    chk_resp_off: assert property ($fell(slave_select_n) |-> ##[0:20] !slave_resp_en) else $error("resp kept");
    cover property ($rose(engine_stall));
    cover property ($fell(slave_resp_en));
    cover property ($fell(miso_oe));
endmodule
`default_nettype wire

// ### testbench/test_spi_slave_command_frontend.sv
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module test_spi_slave_command_frontend;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, engine_busy, note, slave_resp_en, engine_stall;
    logic [3:0] avs_address;
    logic [7:0] bus_xfer_status, a;
    logic [31:0] avs_writedata, avs_readdata, r, sh, expq[$];
    sscf_pkg::sscf_regs_t cfg_regs, m = sscf_pkg::REG_RESET;
    int failures = 0, num_checks = 0, cyc = 0, stall_cyc = 0;
    sscf_link_if lnk ();
    sscf_dev i_sscf_dev (.clk, .rst_n, .link(lnk.dev), .engine_busy, .bus_xfer_status, .cfg_regs, .slave_resp_en,
        .engine_stall);
    // Select is driven rather than tied low, so frames stay delimited
    sscf_host i_sscf_host (.clk, .rst_n, .link(lnk.host), .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest);
    sscf_link_checker i_sscf_link_checker (.clk, .rst_n, .sclk(lnk.sclk), .slave_select_n(lnk.slave_select_n),
        .miso_oe(lnk.miso_oe), .engine_busy, .engine_stall, .slave_resp_en);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge lnk.sclk) if (!lnk.slave_select_n) sh <= {sh[30:0], lnk.mosi};
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!lnk.slave_select_n && engine_stall === 1'b1) stall_cyc <= stall_cyc + 1;
        if (avs_read && note && avs_waitrequest === 1'b0) cmp_rd(avs_readdata, expq.pop_front());
        if (cyc == 40000) begin
            failures++;
            results();
        end
    end
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        cmp_val(80'(got), 80'(exp));
    endtask
    task automatic cmp_val(input logic [79:0] got, input logic [79:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic [3:0] ad, input logic w, input logic [31:0] d, input logic nt);
        @(posedge clk);
        {avs_address, avs_write, avs_read, avs_writedata, note} <= {ad, w, !w, d, nt};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
    endtask
    // Random engine load on every command; a stall must track it
    task automatic op(input logic [1:0] c, input logic [7:0] ad, input logic [7:0] d);
        int s0;
        engine_busy <= 1'($urandom);
        s0 = stall_cyc;
        bus(sscf_pkg::CSR_ADDR, 1'b1, {24'h0, ad}, 1'b0);
        bus(sscf_pkg::CSR_DATA, 1'b1, {24'h0, d}, 1'b0);
        bus(sscf_pkg::CSR_CMD, 1'b1, {30'h0, c}, 1'b0);
        do bus(sscf_pkg::CSR_STAT, 1'b0, 32'h0, 1'b0); while (r[8] !== 1'b0);
        repeat (8) @(posedge clk);
        cmp_val(80'({stall_cyc != s0, engine_stall}), 80'({engine_busy, 1'b0}));
    endtask
    initial begin
        void'($urandom(32'h8203ede5));
        {rst_n, avs_read, avs_write, engine_busy, note, avs_address, avs_writedata, bus_xfer_status} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        cmp_val(80'(cfg_regs), 80'(m));
        cmp_val(80'({slave_resp_en, engine_stall}), 80'h0);
        bus_xfer_status <= 8'($urandom);
        // Odd values keep the own address nonzero
        for (int i = 0; i < 11; i++) begin
            a = 8'($urandom) | 8'h01;
            op(sscf_pkg::OP_REG_WR, 8'(i), a);
            if (i != 4 && i < 10) m[i] = a;
            cmp_val(80'(cfg_regs), 80'(m));
            cmp_val(80'(sh[23:16]), 80'h20);
        end
        for (int k = 0; k < 3; k++) begin
            op(sscf_pkg::OP_ORDER, 8'h00, k == 0 ? 8'h42 : (k == 1 ? 8'h55 : 8'h81));
            for (int i = 0; i < 11; i++) begin
                op(sscf_pkg::OP_REG_RD, 8'(i), 8'h00);
                expq.push_back({22'h0, 1'(k < 2), 1'b0, i == 4 ? bus_xfer_status : (i < 10 ? m[i] : 8'h00)});
                bus(sscf_pkg::CSR_STAT, 1'b0, 32'h0, 1'b1);
            end
            cmp_val(80'(sh[31:24]), k < 2 ? 80'h84 : 80'h21);
        end
        cmp_val(80'(slave_resp_en), 80'h1);
        results();
    end
endmodule
`default_nettype wire
